/* logic/dmf_core.sv */
/*
 data memory, working register, flag register and interrupt entry.
 assumes an execution unit that issues one access per cycle,
 owns the return stack and reports when it is full.
*/
`default_nettype none
module dmf_core #(
	parameter int GP_DEPTH = dmf_pkg::DMF_GP_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// read port
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data_q,
	// plain write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// single bit set or clear
	input wire logic bit_en,
	input wire logic [7:0] bit_addr,
	input wire logic [2:0] bit_idx,
	input wire logic bit_val,
	// alu
	input wire logic alu_en,
	input wire dmf_pkg::dmf_op_t alu_op,
	input wire logic [7:0] alu_operand,
	input wire logic alu_to_mem,
	input wire logic [7:0] alu_dest,
	output logic [7:0] working_reg,
	output logic [7:0] flag_reg,
	// instruction events
	input wire logic halt_instr,
	input wire logic watchdog_clear_instr,
	input wire logic watchdog_timeout,
	input wire logic irq_return_instr,
	input wire logic instr_boundary,
	input wire logic stack_full,
	// request sources
	input wire logic ext_irq_n,
	input wire logic t0_req,
	input wire logic t1_req,
	input wire logic adc_req,
	input wire logic bus_req,
	// interrupt entry
	output logic irq_call_q,
	output logic [7:0] irq_vector_q,
	output logic halted,
	output logic wake_q
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] ram_q [GP_DEPTH];
	logic [7:0] ram_d [GP_DEPTH];
	logic [7:0] ptr_reg_zero_q, ptr_reg_zero_d;
	logic [7:0] ptr_reg_one_q, ptr_reg_one_d;
	logic [7:0] working_reg_q, working_reg_d;
	logic [7:0] flag_q, flag_d;
	logic [7:0] irq_ctrl_zero_q, irq_ctrl_zero_d;
	logic [7:0] irq_ctrl_one_q, irq_ctrl_one_d;
	logic [7:0] rd_data_d;
	logic irq_call_d, wake_d;
	logic [7:0] irq_vector_d;
	dmf_pkg::dmf_state_t state_q, state_d;

	logic ext_fall;
	logic [7:0] alu_result;
	logic alu_c, alu_h, alu_z, alu_v;
	logic upd_arith, upd_zero, upd_carry;

	logic wr_go;
	logic [7:0] wr_a, wr_v, bit_old;
	logic [8:0] wr_res, rd_res, bit_res;
	logic [4:0] pend_vec, en_vec;
	logic any_pend, any_ready, take;
	logic [7:0] take_vec;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// {valid, physical address}; windows resolve through pointers
	function automatic logic [8:0] resolve(input logic [7:0] a);
		logic [7:0] t;
		t = a;
		if (a == dmf_pkg::DMF_IND0)
			t = ptr_reg_zero_q;
		else if (a == dmf_pkg::DMF_IND1)
			t = ptr_reg_one_q;
		resolve = {!(t == dmf_pkg::DMF_IND0 || t == dmf_pkg::DMF_IND1), t};
	endfunction

	function automatic logic [7:0] fetch(input logic [8:0] r);
		logic [7:0] v;
		v = dmf_pkg::DMF_ZERO;
		if (r[8]) begin
			unique case (r[7:0])
				dmf_pkg::DMF_PTR0: v = ptr_reg_zero_q;
				dmf_pkg::DMF_PTR1: v = ptr_reg_one_q;
				dmf_pkg::DMF_WORK: v = working_reg_q;
				dmf_pkg::DMF_FLAG: v = flag_q;
				dmf_pkg::DMF_IRQC0: v = irq_ctrl_zero_q & dmf_pkg::DMF_C0_MASK;
				dmf_pkg::DMF_IRQC1: v = irq_ctrl_one_q & dmf_pkg::DMF_C1_MASK;
				default: begin
					if (r[7:0] >= dmf_pkg::DMF_GP_BASE)
						v = ram_q[gp_index(r[7:0])];
				end
			endcase
		end
		fetch = v;
	endfunction

	function automatic int gp_index(input logic [7:0] a);
		gp_index = int'(a - dmf_pkg::DMF_GP_BASE);
	endfunction

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	dmf_edge_sync u_sync (
		.clock(clock),
		.resetn(resetn),
		.pin_n(ext_irq_n),
		.fall(ext_fall)
	);

	dmf_flag_alu u_alu (
		.op(alu_op),
		.a(working_reg_q),
		.b(alu_operand),
		.cin(flag_q[dmf_pkg::DMF_F_CARRY]),
		.result(alu_result),
		.carry(alu_c),
		.half(alu_h),
		.zero(alu_z),
		.sign_err(alu_v),
		.upd_arith(upd_arith),
		.upd_zero(upd_zero),
		.upd_carry(upd_carry)
	);

	// ---------------------------------------------------------------
	// interrupt selection
	// ---------------------------------------------------------------
	always_comb begin
		pend_vec = {irq_ctrl_one_q[dmf_pkg::DMF_C1_BUS_PEND],
			irq_ctrl_one_q[dmf_pkg::DMF_C1_ADC_PEND],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_T1_PEND],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_T0_PEND],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_EXT_PEND]};
		en_vec = {irq_ctrl_one_q[dmf_pkg::DMF_C1_BUS_EN],
			irq_ctrl_one_q[dmf_pkg::DMF_C1_ADC_EN],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_T1_EN],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_T0_EN],
			irq_ctrl_zero_q[dmf_pkg::DMF_C0_EXT_EN]};
		any_pend = |pend_vec;
		any_ready = |(pend_vec & en_vec);
		take = any_ready && irq_ctrl_zero_q[dmf_pkg::DMF_C0_GATE]
			&& !stack_full && instr_boundary
			&& (state_q == dmf_pkg::DMF_ST_RUN);
		// fixed priority, external first
		take_vec = dmf_pkg::DMF_VEC_BUS;
		if ((pend_vec[0] & en_vec[0]) == 1'b1)
			take_vec = dmf_pkg::DMF_VEC_EXT;
		else if ((pend_vec[1] & en_vec[1]) == 1'b1)
			take_vec = dmf_pkg::DMF_VEC_T0;
		else if ((pend_vec[2] & en_vec[2]) == 1'b1)
			take_vec = dmf_pkg::DMF_VEC_T1;
		else if ((pend_vec[3] & en_vec[3]) == 1'b1)
			take_vec = dmf_pkg::DMF_VEC_ADC;
	end

	// ---------------------------------------------------------------
	// write source selection
	// ---------------------------------------------------------------
	always_comb begin
		bit_res = resolve(bit_addr);
		bit_old = fetch(bit_res);
		rd_res = resolve(rd_addr);
		wr_go = 1'b1;
		wr_a = wr_addr;
		wr_v = wr_data;
		if (alu_en && alu_to_mem) begin
			wr_a = alu_dest;
			wr_v = alu_result;
		end else if (bit_en) begin
			wr_a = bit_addr;
			wr_v = bit_old;
			wr_v[bit_idx] = bit_val;
		end else if (!wr_en) begin
			wr_go = 1'b0;
		end
		wr_res = resolve(wr_a);
	end

	// ---------------------------------------------------------------
	// register next values
	// ---------------------------------------------------------------
	always_comb begin
		ram_d = ram_q;
		ptr_reg_zero_d = ptr_reg_zero_q;
		ptr_reg_one_d = ptr_reg_one_q;
		working_reg_d = working_reg_q;
		flag_d = flag_q;
		irq_ctrl_zero_d = irq_ctrl_zero_q;
		irq_ctrl_one_d = irq_ctrl_one_q;
		// software write, one location per cycle
		if (wr_go && wr_res[8]) begin
			unique case (wr_res[7:0])
				dmf_pkg::DMF_PTR0: ptr_reg_zero_d = wr_v;
				dmf_pkg::DMF_PTR1: ptr_reg_one_d = wr_v;
				dmf_pkg::DMF_WORK: working_reg_d = wr_v;
				dmf_pkg::DMF_FLAG: flag_d = (flag_q & ~dmf_pkg::DMF_FLAG_WMASK)
					| (wr_v & dmf_pkg::DMF_FLAG_WMASK);
				dmf_pkg::DMF_IRQC0: irq_ctrl_zero_d = wr_v & dmf_pkg::DMF_C0_MASK;
				dmf_pkg::DMF_IRQC1: irq_ctrl_one_d = wr_v & dmf_pkg::DMF_C1_MASK;
				default: begin
					if (wr_res[7:0] >= dmf_pkg::DMF_GP_BASE)
						ram_d[gp_index(wr_res[7:0])] = wr_v;
				end
			endcase
		end
		// alu result and flags win over a plain write
		if (alu_en) begin
			if (!alu_to_mem)
				working_reg_d = alu_result;
			if (upd_carry)
				flag_d[dmf_pkg::DMF_F_CARRY] = alu_c;
			if (upd_arith) begin
				flag_d[dmf_pkg::DMF_F_HALF] = alu_h;
				flag_d[dmf_pkg::DMF_F_SIGN] = alu_v;
			end
			if (upd_zero)
				flag_d[dmf_pkg::DMF_F_ZERO] = alu_z;
		end
		// halt and watchdog flags
		if (watchdog_clear_instr) begin
			flag_d[dmf_pkg::DMF_F_HALT] = 1'b0;
			flag_d[dmf_pkg::DMF_F_WDOG] = 1'b0;
		end
		if (halt_instr) begin
			flag_d[dmf_pkg::DMF_F_HALT] = 1'b1;
			flag_d[dmf_pkg::DMF_F_WDOG] = 1'b0;
		end
		if (watchdog_timeout)
			flag_d[dmf_pkg::DMF_F_WDOG] = 1'b1;
		flag_d[7:6] = 2'b00;
		// gate reopened by interrupt return or a write to control zero
		if (irq_return_instr)
			irq_ctrl_zero_d[dmf_pkg::DMF_C0_GATE] = 1'b1;
		// service: close gate, drop the taken flag
		if (take) begin
			irq_ctrl_zero_d[dmf_pkg::DMF_C0_GATE] = 1'b0;
			unique case (take_vec)
				dmf_pkg::DMF_VEC_EXT: irq_ctrl_zero_d[dmf_pkg::DMF_C0_EXT_PEND] = 1'b0;
				dmf_pkg::DMF_VEC_T0: irq_ctrl_zero_d[dmf_pkg::DMF_C0_T0_PEND] = 1'b0;
				dmf_pkg::DMF_VEC_T1: irq_ctrl_zero_d[dmf_pkg::DMF_C0_T1_PEND] = 1'b0;
				dmf_pkg::DMF_VEC_ADC: irq_ctrl_one_d[dmf_pkg::DMF_C1_ADC_PEND] = 1'b0;
				default: irq_ctrl_one_d[dmf_pkg::DMF_C1_BUS_PEND] = 1'b0;
			endcase
		end
		// new requests set last, so they beat any clear
		if (ext_fall)
			irq_ctrl_zero_d[dmf_pkg::DMF_C0_EXT_PEND] = 1'b1;
		if (t0_req)
			irq_ctrl_zero_d[dmf_pkg::DMF_C0_T0_PEND] = 1'b1;
		if (t1_req)
			irq_ctrl_zero_d[dmf_pkg::DMF_C0_T1_PEND] = 1'b1;
		if (adc_req)
			irq_ctrl_one_d[dmf_pkg::DMF_C1_ADC_PEND] = 1'b1;
		if (bus_req)
			irq_ctrl_one_d[dmf_pkg::DMF_C1_BUS_PEND] = 1'b1;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < GP_DEPTH; i++) begin
				ram_q[i] <= 8'h00;
			end
			ptr_reg_zero_q <= 8'h00;
			ptr_reg_one_q <= 8'h00;
			working_reg_q <= 8'h00;
			flag_q <= dmf_pkg::DMF_FLAG_RST;
			irq_ctrl_zero_q <= dmf_pkg::DMF_C_RST;
			irq_ctrl_one_q <= dmf_pkg::DMF_C_RST;
		end else begin
			ram_q <= ram_d;
			ptr_reg_zero_q <= ptr_reg_zero_d;
			ptr_reg_one_q <= ptr_reg_one_d;
			working_reg_q <= working_reg_d;
			flag_q <= flag_d;
			irq_ctrl_zero_q <= irq_ctrl_zero_d;
			irq_ctrl_one_q <= irq_ctrl_one_d;
		end
	end

	// ---------------------------------------------------------------
	// read data, halt state and entry strobe
	// ---------------------------------------------------------------
	always_comb begin
		rd_data_d = rd_en ? fetch(rd_res) : rd_data_q;
		state_d = state_q;
		wake_d = 1'b0;
		unique case (state_q)
			dmf_pkg::DMF_ST_RUN: begin
				if (halt_instr)
					state_d = dmf_pkg::DMF_ST_HALT;
			end
			dmf_pkg::DMF_ST_HALT: begin
				if (any_pend) begin
					state_d = dmf_pkg::DMF_ST_RUN;
					wake_d = 1'b1;
				end
			end
		endcase
		// only the return address is stacked; flags stay put
		irq_call_d = take;
		irq_vector_d = take ? take_vec : irq_vector_q;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_data_q <= 8'h00;
			state_q <= dmf_pkg::DMF_ST_RUN;
			wake_q <= 1'b0;
			irq_call_q <= 1'b0;
			irq_vector_q <= 8'h00;
		end else begin
			rd_data_q <= rd_data_d;
			state_q <= state_d;
			wake_q <= wake_d;
			irq_call_q <= irq_call_d;
			irq_vector_q <= irq_vector_d;
		end
	end

	assign working_reg = working_reg_q;
	assign flag_reg = flag_q;
	assign halted = (state_q == dmf_pkg::DMF_ST_HALT);
endmodule
`default_nettype wire

/* logic/dmf_pkg.sv */
/*
 data memory, flags and interrupt entry: shared constants and types.
 assumes one clock, asynchronous active-low reset.
*/
// Operation
// - 231 byte space: 39 special, 192 general
// - general storage spans 40h to ffh
// - unimplemented low locations read as zero
// - low locations identical in every bank
// - windows 00h/02h reach ram via pointers
// - pointer to a window: read zero, write ignored
// - no move between the two windows
// - working reg at 05h carries all moves
// - bit set/clear and alu on every location
// - flags at 0ah, bits 6-7 read zero
// - bit 0 carry/no borrow, rotate through carry
// - bit 1 low nibble carry/no borrow
// - bit 2 set on zero result
// - bit 3 carry into top differs carry out
// - bit 4 clear at reset/wdog clear, set halt
// - bit 5 clear reset/clear/halt, set timeout
// - plain writes keep bits 4 and 5
// - flags never saved on call or irq
// - service closes gate, requests only pend
// - full stack holds off acknowledge
// - every source wakes from halt
// - falling pin edge pends, vector 04h
// - irq return reopens gate, plain return not
// - gate is bit 0 of control zero
// - pending flags stay until serviced or cleared
`default_nettype none
package dmf_pkg;
	// ---------------------------------------------------------------
	// map
	// ---------------------------------------------------------------
	localparam logic [7:0] DMF_IND0 = 8'h00;
	localparam logic [7:0] DMF_PTR0 = 8'h01;
	localparam logic [7:0] DMF_IND1 = 8'h02;
	localparam logic [7:0] DMF_PTR1 = 8'h03;
	localparam logic [7:0] DMF_WORK = 8'h05;
	localparam logic [7:0] DMF_FLAG = 8'h0a;
	localparam logic [7:0] DMF_IRQC0 = 8'h0b;
	localparam logic [7:0] DMF_IRQC1 = 8'h1e;
	localparam logic [7:0] DMF_GP_BASE = 8'h40;
	localparam int DMF_GP_DEPTH = 192;
	localparam logic [7:0] DMF_ZERO = 8'h00;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int DMF_F_CARRY = 0;
	localparam int DMF_F_HALF = 1;
	localparam int DMF_F_ZERO = 2;
	localparam int DMF_F_SIGN = 3;
	localparam int DMF_F_HALT = 4;
	localparam int DMF_F_WDOG = 5;
	localparam logic [7:0] DMF_FLAG_WMASK = 8'h0f;
	localparam logic [7:0] DMF_FLAG_RST = 8'h00;
	localparam int DMF_C0_GATE = 0;
	localparam int DMF_C0_EXT_EN = 1;
	localparam int DMF_C0_T0_EN = 2;
	localparam int DMF_C0_T1_EN = 3;
	localparam int DMF_C0_EXT_PEND = 4;
	localparam int DMF_C0_T0_PEND = 5;
	localparam int DMF_C0_T1_PEND = 6;
	localparam logic [7:0] DMF_C0_MASK = 8'h7f;
	localparam int DMF_C1_ADC_EN = 0;
	localparam int DMF_C1_BUS_EN = 1;
	localparam int DMF_C1_ADC_PEND = 4;
	localparam int DMF_C1_BUS_PEND = 5;
	localparam logic [7:0] DMF_C1_MASK = 8'h33;
	localparam logic [7:0] DMF_C_RST = 8'h00;
	localparam logic [7:0] DMF_VEC_EXT = 8'h04;
	localparam logic [7:0] DMF_VEC_T0 = 8'h08;
	localparam logic [7:0] DMF_VEC_T1 = 8'h0c;
	localparam logic [7:0] DMF_VEC_ADC = 8'h10;
	localparam logic [7:0] DMF_VEC_BUS = 8'h14;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		DMF_OP_PASS = 4'h0, DMF_OP_ADD = 4'h1, DMF_OP_ADC = 4'h2,
		DMF_OP_SUB = 4'h3, DMF_OP_SBC = 4'h4, DMF_OP_AND = 4'h5,
		DMF_OP_OR = 4'h6, DMF_OP_XOR = 4'h7, DMF_OP_CPL = 4'h8,
		DMF_OP_RL = 4'h9, DMF_OP_RR = 4'ha, DMF_OP_RLC = 4'hb,
		DMF_OP_RRC = 4'hc, DMF_OP_INC = 4'hd, DMF_OP_DEC = 4'he
	} dmf_op_t;
	typedef enum logic [1:0] {
		DMF_ST_RUN = 2'b01,
		DMF_ST_HALT = 2'b10
	} dmf_state_t;
endpackage
`default_nettype wire

/* logic/dmf_edge_sync.sv */
/*
 falling-edge detector for the external request pin.
 assumes the pin is idle high and may be asynchronous.
*/
`default_nettype none
module dmf_edge_sync (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// pin and event
	input wire logic pin_n,
	output logic fall
);
	logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

	// ---------------------------------------------------------------
	// two-stage synchroniser, then edge
	// ---------------------------------------------------------------
	always_comb begin
		meta_d = pin_n;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign fall = prev_q & ~sync_q;
endmodule
`default_nettype wire

/* logic/dmf_flag_alu.sv */
/*
 eight-bit alu with flag outputs and update strobes for carry, zero and half/sign.
 assumes operands and carry-in are stable within the cycle.
*/
`default_nettype none
module dmf_flag_alu (
	// operation
	input wire dmf_pkg::dmf_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	// result and flags
	output logic [7:0] result,
	output logic carry,
	output logic half,
	output logic zero,
	output logic sign_err,
	output logic upd_arith,
	output logic upd_zero,
	output logic upd_carry
);
	logic [7:0] bb;
	logic ci;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] low7;

	always_comb begin
		bb = b;
		ci = 1'b0;
		upd_arith = 1'b0;
		upd_zero = 1'b1;
		upd_carry = 1'b0;
		carry = cin;
		unique case (op)
			dmf_pkg::DMF_OP_ADC: ci = cin;
			dmf_pkg::DMF_OP_SUB: begin
				bb = ~b;
				ci = 1'b1;
			end
			dmf_pkg::DMF_OP_SBC: begin
				bb = ~b;
				ci = cin;
			end
			default: ;
		endcase
		sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
		half = nib[4];
		sign_err = low7[7] ^ sum[8];
		unique case (op)
			dmf_pkg::DMF_OP_ADD, dmf_pkg::DMF_OP_ADC,
			dmf_pkg::DMF_OP_SUB, dmf_pkg::DMF_OP_SBC: begin
				result = sum[7:0];
				carry = sum[8];
				upd_arith = 1'b1;
				upd_carry = 1'b1;
			end
			dmf_pkg::DMF_OP_AND: result = a & b;
			dmf_pkg::DMF_OP_OR: result = a | b;
			dmf_pkg::DMF_OP_XOR: result = a ^ b;
			dmf_pkg::DMF_OP_CPL: result = ~b;
			dmf_pkg::DMF_OP_INC: result = b + 8'h01;
			dmf_pkg::DMF_OP_DEC: result = b - 8'h01;
			dmf_pkg::DMF_OP_RL: begin
				result = {b[6:0], b[7]};
				upd_zero = 1'b0;
			end
			dmf_pkg::DMF_OP_RR: begin
				result = {b[0], b[7:1]};
				upd_zero = 1'b0;
			end
			dmf_pkg::DMF_OP_RLC: begin
				result = {b[6:0], cin};
				carry = b[7];
				upd_carry = 1'b1;
				upd_zero = 1'b0;
			end
			dmf_pkg::DMF_OP_RRC: begin
				result = {cin, b[7:1]};
				carry = b[0];
				upd_carry = 1'b1;
				upd_zero = 1'b0;
			end
			default: begin
				result = b;
				upd_zero = 1'b0;
			end
		endcase
		zero = (result == 8'h00);
	end
endmodule
`default_nettype wire

/* dv/dmf_core_sva.sv */
/*
 port checker for dmf_core.
 assumes it is bound to every dmf_core instance.
*/
`default_nettype none
module dmf_core_sva #(
	parameter int GP_DEPTH = dmf_pkg::DMF_GP_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// data ports
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data_q,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic bit_en,
	input wire logic alu_en,
	input wire dmf_pkg::dmf_op_t alu_op,
	input wire logic [7:0] alu_operand,
	input wire logic [7:0] working_reg,
	input wire logic [7:0] flag_reg,
	// events and interrupt entry
	input wire logic halt_instr,
	input wire logic watchdog_clear_instr,
	input wire logic watchdog_timeout,
	input wire logic irq_return_instr,
	input wire logic instr_boundary,
	input wire logic stack_full,
	input wire logic irq_call_q,
	input wire logic halted,
	input wire logic wake_q
);
	// ----
	// helpers
	// ----
	logic [8:0] add_w;
	logic add_c;
	logic add_z;
	assign add_w = {1'b0, working_reg} + {1'b0, alu_operand};
	assign add_c = add_w[8];
	assign add_z = add_w[7:0] == 8'h00;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ----
	// properties
	// ----
	a_reserved_zero: assert property (
		rd_en && rd_addr inside {[8'h2a:8'h3f]} |=> rd_data_q == 8'h00)
		else $error("reserved read not zero");
	a_flag_top_zero: assert property (
		flag_reg[7:6] == 2'b00)
		else $error("flag top bits set");
	a_halt_flags: assert property (
		halt_instr && !watchdog_timeout && !watchdog_clear_instr |=> flag_reg[5:4] == 2'b01)
		else $error("halt flags wrong");
	a_timeout_flag: assert property (
		watchdog_timeout |=> flag_reg[5])
		else $error("timeout flag not set");
	a_clear_flags: assert property (
		watchdog_clear_instr && !watchdog_timeout && !halt_instr |=> flag_reg[5:4] == 2'b00)
		else $error("watchdog clear flags wrong");
	a_write_flags: assert property (
		wr_en && wr_addr == 8'h0a && !alu_en && !bit_en && !halt_instr
		&& !watchdog_clear_instr && !watchdog_timeout
		|=> flag_reg[3:0] == $past(wr_data[3:0]) && $stable(flag_reg[5:4]))
		else $error("flag write wrong");
	a_add_flags: assert property (
		alu_en && alu_op == dmf_pkg::DMF_OP_ADD
		|=> flag_reg[0] == $past(add_c) && flag_reg[2] == $past(add_z))
		else $error("add flags wrong");
	a_full_holds: assert property (
		stack_full || !instr_boundary || halted |=> !irq_call_q)
		else $error("entry while held off");
	a_gate_closes: assert property (
		irq_call_q && !$past(wr_en) && !$past(bit_en) && !$past(alu_en)
		&& !$past(irq_return_instr) |-> ##1 !irq_call_q)
		else $error("entry with gate closed");
	a_wake_pulse: assert property (
		$fell(halted) |-> wake_q)
		else $error("wake without pulse");
endmodule

bind dmf_core dmf_core_sva #(.GP_DEPTH(GP_DEPTH)) chk_u (
	.clock(clock), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr),
	.rd_data_q(rd_data_q), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
	.bit_en(bit_en), .alu_en(alu_en), .alu_op(alu_op), .alu_operand(alu_operand),
	.working_reg(working_reg), .flag_reg(flag_reg), .halt_instr(halt_instr),
	.watchdog_clear_instr(watchdog_clear_instr), .watchdog_timeout(watchdog_timeout),
	.irq_return_instr(irq_return_instr), .instr_boundary(instr_boundary),
	.stack_full(stack_full), .irq_call_q(irq_call_q), .halted(halted), .wake_q(wake_q)
);
`default_nettype wire

/* dv/tb.sv */
/*
 self-checking bench for dmf_core.
 assumes the package and design files are compiled first.
*/
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// signals
	// ----
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic rd_en = 1'b0, wr_en = 1'b0, bit_en = 1'b0, bit_val = 1'b0, alu_en = 1'b0;
	logic [7:0] rd_addr = 8'h00, wr_addr = 8'h00, wr_data = 8'h00, bit_addr = 8'h00;
	logic [7:0] alu_operand = 8'h00, alu_dest = 8'h00;
	logic [2:0] bit_idx = 3'h0;
	dmf_pkg::dmf_op_t alu_op = dmf_pkg::DMF_OP_PASS;
	logic alu_to_mem = 1'b0, halt_instr = 1'b0, watchdog_clear_instr = 1'b0;
	logic watchdog_timeout = 1'b0, irq_return_instr = 1'b0, t0_req = 1'b0;
	logic instr_boundary = 1'b1, stack_full = 1'b1, ext_irq_n = 1'b1;
	logic t1_req = 1'b0, adc_req = 1'b0, bus_req = 1'b0;
	logic [7:0] rd_data_q, working_reg, flag_reg, irq_vector_q;
	logic irq_call_q, halted, wake_q, rd_v = 1'b0;
	logic [7:0] a, d;
	logic [7:0] mem [256];
	logic [7:0] wl [$];
	logic [7:0] exp_q [$];
	logic [7:0] vec_q [$];
	int mismatches = 0, checked = 0, cycles = 0;
	dmf_pkg::dmf_op_t op_t [8] = '{dmf_pkg::DMF_OP_ADD, dmf_pkg::DMF_OP_SUB,
		dmf_pkg::DMF_OP_ADD, dmf_pkg::DMF_OP_RLC, dmf_pkg::DMF_OP_SBC,
		dmf_pkg::DMF_OP_XOR, dmf_pkg::DMF_OP_INC, dmf_pkg::DMF_OP_RRC};
	logic [7:0] acc_t [8] = '{8'h88, 8'h10, 8'h7f, 8'h00, 8'h50, 8'h5a, 8'h00, 8'h00};
	logic [7:0] opd_t [8] = '{8'h78, 8'h20, 8'h01, 8'h80, 8'h20, 8'h5a, 8'h7f, 8'h02};
	logic [7:0] flg_t [8] = '{8'h07, 8'h02, 8'h0a, 8'h0b, 8'h03, 8'h07, 8'h03, 8'h02};
	logic [7:0] res_t [8] = '{8'h00, 8'hf0, 8'h80, 8'h00, 8'h30, 8'h00, 8'h80, 8'h81};
	logic [7:0] rst_a [6] = '{8'h0a, 8'h0b, 8'h1e, 8'h05, 8'h3f, 8'h04};
	always #4 clock = ~clock;
	dmf_core dut_u (.clock(clock), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.bit_en(bit_en), .bit_addr(bit_addr), .bit_idx(bit_idx), .bit_val(bit_val),
		.alu_en(alu_en), .alu_op(alu_op), .alu_operand(alu_operand),
		.alu_to_mem(alu_to_mem), .alu_dest(alu_dest), .working_reg(working_reg),
		.flag_reg(flag_reg), .halt_instr(halt_instr),
		.watchdog_clear_instr(watchdog_clear_instr), .watchdog_timeout(watchdog_timeout),
		.irq_return_instr(irq_return_instr), .instr_boundary(instr_boundary),
		.stack_full(stack_full), .ext_irq_n(ext_irq_n), .t0_req(t0_req), .t1_req(t1_req),
		.adc_req(adc_req), .bus_req(bus_req), .irq_call_q(irq_call_q),
		.irq_vector_q(irq_vector_q), .halted(halted), .wake_q(wake_q));
	// ----
	// tasks
	// ----
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task test_done;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] wa, input logic [7:0] wd);
		@(posedge clock);
		wr_en <= 1'b1;
		wr_addr <= wa;
		wr_data <= wd;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] ra, input logic [7:0] e);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_addr <= ra;
		exp_q.push_back(e);
		@(posedge clock);
		rd_en <= 1'b0;
	endtask
	task alu(input dmf_pkg::dmf_op_t o, input logic [7:0] b);
		@(posedge clock);
		alu_en <= 1'b1;
		alu_op <= o;
		alu_operand <= b;
		@(posedge clock);
		alu_en <= 1'b0;
	endtask
	task ev(input int k);
		@(posedge clock);
		case (k)
			0: halt_instr <= 1'b1;
			1: watchdog_clear_instr <= 1'b1;
			2: watchdog_timeout <= 1'b1;
			3: irq_return_instr <= 1'b1;
			default: t0_req <= 1'b1;
		endcase
		@(posedge clock);
		{halt_instr, watchdog_clear_instr, watchdog_timeout, irq_return_instr, t0_req} <= 5'h0;
	endtask
	// ----
	// monitor and timeout
	// ----
	always @(posedge clock) begin
		rd_v <= rd_en;
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			test_done;
		end
	end
	always @(negedge clock) begin
		if (rd_v) chk("read", exp_q.pop_front(), rd_data_q);
		if (irq_call_q !== 1'b0) chk("vector", vec_q.size() ? vec_q.pop_front() : 8'hxx, irq_vector_q);
	end
	// ----
	// sequence
	// ----
	initial begin
		void'($urandom(59766));
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		foreach (rst_a[i]) rd(rst_a[i], 8'h00);
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 8'h40 : (i == 1) ? 8'hff : 8'(8'h40 + $urandom % 192);
			d = 8'($urandom);
			mem[a] = d;
			wl.push_back(a);
			wr(a, d);
		end
		foreach (wl[i]) rd(wl[i], mem[wl[i]]);
		wr(8'h01, 8'h41);
		wr(8'h00, 8'hc3);
		rd(8'h41, 8'hc3);
		rd(8'h00, 8'hc3);
		wr(8'h03, 8'h02);
		wr(8'h02, 8'h55);
		rd(8'h02, 8'h00);
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'h0f);
		for (int i = 0; i < 8; i++) begin
			wr(8'h05, acc_t[i]);
			alu(op_t[i], opd_t[i]);
			rd(8'h0a, flg_t[i]);
			rd(8'h05, res_t[i]);
			@(negedge clock);
			chk("flag_reg", flg_t[i], flag_reg);
			chk("working_reg", res_t[i], working_reg);
		end
		@(posedge clock);
		alu_to_mem <= 1'b1;
		alu_dest <= 8'h44;
		alu(dmf_pkg::DMF_OP_CPL, 8'h0f);
		alu_to_mem <= 1'b0;
		rd(8'h44, 8'hf0);
		rd(8'h05, 8'h81);
		wr(8'h43, 8'h01);
		@(posedge clock);
		bit_en <= 1'b1;
		bit_addr <= 8'h43;
		bit_idx <= 3'h7;
		bit_val <= 1'b1;
		@(posedge clock);
		bit_en <= 1'b0;
		rd(8'h43, 8'h81);
		ev(2);
		rd(8'h0a, 8'h22);
		ev(0);
		rd(8'h0a, 8'h12);
		@(negedge clock);
		chk("halted", 8'h01, {7'h0, halted});
		ev(4);
		@(posedge clock);
		@(negedge clock);
		chk("wake_q", 8'h01, {7'h0, wake_q});
		chk("halted", 8'h00, {7'h0, halted});
		ev(1);
		rd(8'h0a, 8'h02);
		rd(8'h0b, 8'h20);
		wr(8'h0b, 8'h07);
		@(posedge clock);
		ext_irq_n <= 1'b0;
		repeat (6) @(posedge clock);
		rd(8'h0b, 8'h17);
		vec_q.push_back(8'h04);
		stack_full <= 1'b0;
		repeat (3) @(posedge clock);
		rd(8'h0b, 8'h06);
		ev(4);
		rd(8'h0b, 8'h26);
		vec_q.push_back(8'h08);
		ev(3);
		repeat (3) @(posedge clock);
		rd(8'h0b, 8'h06);
		ext_irq_n <= 1'b1;
		repeat (4) @(posedge clock);
		wr(8'h1e, 8'h03);
		@(posedge clock);
		{t1_req, adc_req, bus_req} <= 3'h7;
		@(posedge clock);
		{t1_req, adc_req, bus_req} <= 3'h0;
		rd(8'h1e, 8'h33);
		vec_q.push_back(8'h10);
		vec_q.push_back(8'h14);
		ev(3);
		repeat (2) @(posedge clock);
		ev(3);
		repeat (2) @(posedge clock);
		rd(8'h1e, 8'h03);
		rd(8'h0b, 8'h46);
		chk("unserved", 8'h00, 8'(vec_q.size()));
		test_done;
	end
endmodule
`default_nettype wire
